// ### core/settings_readback_response.sv
// Settings readback replies and power-up pin configuration.
// Assumes settings bytes from the store are stable around reset and status inputs share clk_in.
// Behaviour
// - Reply bytes 0-2 are code, status, length.
// - Falling-edge enable sets the detection flag.
// - Rising-edge enable sets the flag; both allowed.
// - Bits 4-3 pick converter reference or off.
// - Bit 2 picks supply or internal DAC reference.
// - Vendor identifier low byte 8, high 9.
// - Product identifier low byte 10, high 11.
// - Attributes byte feeds configuration descriptor unchanged.
// - Current byte advertised as twice milliamperes.
// - Pin reply bytes 4-6 hold pin settings.
// - Output pins drive stored level from reset.
// - Direction bit applies only to general-purpose pins.
// - Pin zero codes: gpio, suspend, receive activity.
// - Pin one codes: gpio, clock, analog, transmit, interrupt.
// - Pin two codes: gpio, configured, analog, DAC.
// - Configured indicator inverts once USB configured.
// - Suspend indicator inverts while in suspend.
// - Clock pin drives divided internal clock.
`timescale 1ns/1ps
module settings_readback_response (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] idle_levels_in,
  input wire logic [7:0] clock_divider_in,
  input wire logic [7:0] chip_flags_in,
  input wire logic [15:0] vendor_id_in,
  input wire logic [15:0] product_id_in,
  input wire logic [7:0] power_attr_in,
  input wire logic [7:0] current_in,
  input wire logic [7:0] pin_zero_byte_in,
  input wire logic [7:0] pin_one_byte_in,
  input wire logic [7:0] pin_two_byte_in,
  input wire logic read_req_in,
  input wire logic read_pins_in,
  input wire logic reply_ready_in,
  output logic reply_valid_out,
  output logic [5:0] reply_index_out,
  output logic [7:0] reply_byte_out,
  output logic reply_last_out,
  output logic [7:0] config_attr_out,
  output logic [8:0] max_power_ma_out,
  output logic [1:0] adc_ref_sel_out,
  output logic adc_ref_off_out,
  output logic dac_ref_supply_out,
  input wire logic usb_configured_in,
  input wire logic suspend_in,
  input wire logic rx_active_in,
  input wire logic tx_active_in,
  input wire logic int_clear_in,
  output logic int_flag_out,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_out,
  output logic [2:0] gpio_level_out,
  output logic [2:1] analog_in_en_out,
  output logic dac_out_en_out
);

  typedef struct packed {
    settings_pkg::reply_phase_type phase;
    logic sel_pins;
    logic [5:0] index;
    logic [7:0] reply_byte;
    logic [7:0] idle;
    logic [7:0] divider;
    logic [7:0] flags;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] attr;
    logic [7:0] current;
    logic [2:0][7:0] pins;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic int_prev;
    logic int_flag;
    logic [2:0] level;
    logic [2:0] oe;
  } main_state_type;

  main_state_type s;
  main_state_type next_s;
  clock_out_if clk_link ();

  // Byte at a given reply position, built from the settings caught at reset
  function automatic logic [7:0] reply_at(input main_state_type st, input logic pins, input logic [5:0] idx);
    logic [7:0] b;
    b = settings_pkg::FILL_BYTE;
    if (idx == settings_pkg::IDX_CODE) begin
      b = settings_pkg::READ_FLASH_CODE;
    end else if (idx == settings_pkg::IDX_STATUS) begin
      b = settings_pkg::STATUS_OK;
    end else if (idx == settings_pkg::IDX_LEN) begin
      b = pins ? settings_pkg::PIN_STRUCT_LEN : settings_pkg::CHIP_STRUCT_LEN;
    end else if (pins) begin
      if (idx >= settings_pkg::IDX_PIN_FIRST && idx <= settings_pkg::IDX_PIN_LAST) begin
        b = st.pins[2'(idx - settings_pkg::IDX_PIN_FIRST)];
      end
    end else begin
      case (idx)
        settings_pkg::IDX_CHIP_FLAGS: b = st.flags;
        settings_pkg::IDX_VID_LO: b = st.vid[7:0];
        settings_pkg::IDX_VID_HI: b = st.vid[15:8];
        settings_pkg::IDX_PID_LO: b = st.pid[7:0];
        settings_pkg::IDX_PID_HI: b = st.pid[15:8];
        settings_pkg::IDX_ATTR: b = st.attr;
        settings_pkg::IDX_CURRENT: b = st.current;
        default: b = settings_pkg::FILL_BYTE;  // Bytes 3-6 and 14-63 read as fill
      endcase
    end
    return b;
  endfunction : reply_at

  // Indicator level: idle level normally, its inverse while the event holds
  function automatic logic indicator(input logic idle_level, input logic active);
    return active ? ~idle_level : idle_level;
  endfunction : indicator

  // Next state: reset capture, reply sequencing, pin muxing and edge detection
  always_comb begin
    settings_pkg::pin_role_type role;
    logic rise;
    logic fall;
    role = settings_pkg::ROLE_NONE;
    rise = 1'b0;
    fall = 1'b0;
    next_s = s;
    if (!rst_n_in) begin
      // Settings are caught on every clock edge while reset is low so the store's values apply from release
      next_s = '0;
      next_s.phase = settings_pkg::PHASE_IDLE;
      next_s.idle = idle_levels_in;
      next_s.divider = clock_divider_in;
      next_s.flags = chip_flags_in;
      next_s.vid = vendor_id_in;
      next_s.pid = product_id_in;
      next_s.attr = power_attr_in;
      next_s.current = current_in;
      next_s.pins = {pin_two_byte_in, pin_one_byte_in, pin_zero_byte_in};
      // Synchronisers keep tracking the pin so a pin that idles high fakes no edge at release
      next_s.sync1 = pin_in;
      next_s.sync2 = s.sync1;
      next_s.int_prev = s.sync2[1];
    end else begin
      // Reply stream: a request while a reply runs is ignored
      case (s.phase)
        settings_pkg::PHASE_IDLE: begin
          if (read_req_in) begin
            next_s.phase = settings_pkg::PHASE_SEND;
            next_s.sel_pins = read_pins_in;
            next_s.index = settings_pkg::IDX_CODE;
            next_s.reply_byte = reply_at(s, read_pins_in, settings_pkg::IDX_CODE);
          end
        end
        settings_pkg::PHASE_SEND: begin
          if (reply_ready_in) begin
            if (s.index == settings_pkg::IDX_LAST) begin
              next_s.phase = settings_pkg::PHASE_IDLE;
            end else begin
              next_s.index = s.index + 6'h01;
              next_s.reply_byte = reply_at(s, s.sel_pins, s.index + 6'h01);
            end
          end
        end
        default: next_s.phase = settings_pkg::PHASE_IDLE;
      endcase

      // Two-stage synchronisers on the pins; only the second stage is used
      next_s.sync1 = pin_in;
      next_s.sync2 = s.sync1;
      next_s.int_prev = s.sync2[1];

      // Edge detection only while pin one is the interrupt input; set beats clear
      if (settings_pkg::decode_role(2'h1, s.pins[1][settings_pkg::BIT_PIN_CODE_HI:0]) ==
          settings_pkg::ROLE_INTERRUPT) begin
        fall = s.flags[settings_pkg::BIT_INT_FALL] && s.int_prev && !s.sync2[1];
        rise = s.flags[settings_pkg::BIT_INT_RISE] && !s.int_prev && s.sync2[1];
      end
      if (fall || rise) begin
        next_s.int_flag = 1'b1;
      end else if (int_clear_in) begin
        next_s.int_flag = 1'b0;
      end

      // Pin function per designation code
      for (int i = 0; i < 3; i++) begin
        role = settings_pkg::decode_role(2'(i), s.pins[i][settings_pkg::BIT_PIN_CODE_HI:0]);
        next_s.oe[i] = 1'b0;
        next_s.level[i] = 1'b0;
        case (role)
          settings_pkg::ROLE_GPIO: begin
            next_s.oe[i] = ~s.pins[i][settings_pkg::BIT_PIN_DIR];
            next_s.level[i] = s.pins[i][settings_pkg::BIT_PIN_LEVEL];
          end
          settings_pkg::ROLE_SUSPEND: begin
            next_s.oe[i] = 1'b1;
            next_s.level[i] = indicator(s.idle[settings_pkg::BIT_SUSPEND_IDLE], suspend_in);
          end
          settings_pkg::ROLE_RX: begin
            next_s.oe[i] = 1'b1;
            next_s.level[i] = indicator(s.idle[settings_pkg::BIT_RX_IDLE], rx_active_in);
          end
          settings_pkg::ROLE_TX: begin
            next_s.oe[i] = 1'b1;
            next_s.level[i] = indicator(s.idle[settings_pkg::BIT_TX_IDLE], tx_active_in);
          end
          settings_pkg::ROLE_CONFIGURED: begin
            next_s.oe[i] = 1'b1;
            next_s.level[i] = indicator(s.idle[settings_pkg::BIT_CONFIG_IDLE], usb_configured_in);
          end
          settings_pkg::ROLE_CLOCK: begin
            next_s.oe[i] = 1'b1;
            next_s.level[i] = clk_link.level;
          end
          default: begin
            next_s.oe[i] = 1'b0;  // Analog, DAC, interrupt and undefined codes leave the pin undriven
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    s <= next_s;
  end

  // Clock output divider sits on pin one only
  assign clk_link.enable = settings_pkg::decode_role(2'h1, s.pins[1][settings_pkg::BIT_PIN_CODE_HI:0]) ==
                           settings_pkg::ROLE_CLOCK;
  assign clk_link.divider = s.divider[settings_pkg::BIT_DIVIDER_HI:0];

  clock_out_divider divider_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .link(clk_link)
  );

  // Reply port
  assign reply_valid_out = s.phase == settings_pkg::PHASE_SEND;
  assign reply_index_out = s.index;
  assign reply_byte_out = s.reply_byte;
  assign reply_last_out = reply_valid_out && s.index == settings_pkg::IDX_LAST;

  // Enumeration and converter settings straight from the stored bytes
  assign config_attr_out = s.attr;
  assign max_power_ma_out = 9'(s.current) * 9'(settings_pkg::MA_PER_UNIT);
  assign adc_ref_sel_out = s.flags[settings_pkg::BIT_ADC_REF_HI:settings_pkg::BIT_ADC_REF_LO];
  assign adc_ref_off_out = adc_ref_sel_out == settings_pkg::ADC_REF_OFF;
  assign dac_ref_supply_out = s.flags[settings_pkg::BIT_DAC_SUPPLY];

  // Pins and status
  assign int_flag_out = s.int_flag;
  assign pin_out = s.level;
  assign pin_oe_out = s.oe;
  assign gpio_level_out = s.sync2;
  assign analog_in_en_out[1] = settings_pkg::decode_role(2'h1, s.pins[1][settings_pkg::BIT_PIN_CODE_HI:0]) ==
                               settings_pkg::ROLE_ANALOG;
  assign analog_in_en_out[2] = settings_pkg::decode_role(2'h2, s.pins[2][settings_pkg::BIT_PIN_CODE_HI:0]) ==
                               settings_pkg::ROLE_ANALOG;
  assign dac_out_en_out = settings_pkg::decode_role(2'h2, s.pins[2][settings_pkg::BIT_PIN_CODE_HI:0]) ==
                          settings_pkg::ROLE_DAC;

  // Checks
  sequence reply_start;
    !reply_valid_out ##1 reply_valid_out;
  endsequence

  sequence byte_taken;
    reply_valid_out && reply_ready_in;
  endsequence

  a_reply_header: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reply_start |-> reply_index_out == 6'h00 && reply_byte_out == 8'hb0)
    else $error("Reply did not open with the read command code");

  a_reply_status: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reply_start ##0 byte_taken |=> reply_index_out == 6'h01 && reply_byte_out == 8'h00)
    else $error("Reply status byte wrong");

  a_reply_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_taken ##0 reply_last_out |=> !reply_valid_out)
    else $error("Reply ran past byte 63");

  a_vendor_bytes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reply_valid_out && !s.sel_pins && reply_index_out == 6'h08 && reply_ready_in |=>
    reply_byte_out == s.vid[15:8])
    else $error("Vendor identifier high byte misplaced");

  a_product_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reply_valid_out && !s.sel_pins && reply_index_out == 6'h0a |-> reply_byte_out == s.pid[7:0])
    else $error("Product identifier low byte misplaced");

  a_fall_sets_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.flags[6] && s.pins[1][2:0] == 3'h4 && $fell(s.sync2[1]) |=> int_flag_out)
    else $error("Falling edge missed");

  a_rise_sets_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.flags[5] && s.pins[1][2:0] == 3'h4 && $rose(s.sync2[1]) |=> int_flag_out)
    else $error("Rising edge missed");

  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    int_flag_out && !int_clear_in |=> int_flag_out)
    else $error("Detection flag dropped without a clear");

  a_reference_caught: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> adc_ref_sel_out == $past(chip_flags_in[4:3]) &&
    dac_ref_supply_out == $past(chip_flags_in[2]))
    else $error("Reference choice not taken from stored settings");

  a_current_twice: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> max_power_ma_out == {$past(current_in), 1'b0} &&
    config_attr_out == $past(power_attr_in))
    else $error("Requested current or attributes not taken from stored settings");

  a_gpio_output: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.pins[0][2:0] == 3'h0 && !s.pins[0][3] |=> pin_oe_out[0] && pin_out[0] == s.pins[0][4])
    else $error("Output pin not driving its stored level");

  a_configured_ind: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.pins[2][2:0] == 3'h1 |=> pin_oe_out[2] && pin_out[2] == (s.idle[2] ^ $past(usb_configured_in)))
    else $error("Configured indicator level wrong");

endmodule : settings_readback_response

// ### core/settings_pkg.sv
// Shared constants, enumerations and decoding for the settings readback block.
// Assumes a single 50 MHz device clock and settings bytes held stable by the store.
package settings_pkg;

  // Reply framing
  localparam int REPLY_BYTES = 64;
  localparam logic [7:0] READ_FLASH_CODE = 8'hb0;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] CHIP_STRUCT_LEN = 8'h0e;
  localparam logic [7:0] PIN_STRUCT_LEN = 8'h08;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // Reply byte positions
  localparam logic [5:0] IDX_CODE = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_LEN = 6'h02;
  localparam logic [5:0] IDX_PIN_FIRST = 6'h04;
  localparam logic [5:0] IDX_PIN_LAST = 6'h06;
  localparam logic [5:0] IDX_CHIP_FLAGS = 6'h07;
  localparam logic [5:0] IDX_VID_LO = 6'h08;
  localparam logic [5:0] IDX_VID_HI = 6'h09;
  localparam logic [5:0] IDX_PID_LO = 6'h0a;
  localparam logic [5:0] IDX_PID_HI = 6'h0b;
  localparam logic [5:0] IDX_ATTR = 6'h0c;
  localparam logic [5:0] IDX_CURRENT = 6'h0d;
  localparam logic [5:0] IDX_LAST = 6'h3f;

  // Chip flag byte fields
  localparam int BIT_INT_FALL = 6;
  localparam int BIT_INT_RISE = 5;
  localparam int BIT_ADC_REF_HI = 4;
  localparam int BIT_ADC_REF_LO = 3;
  localparam int BIT_DAC_SUPPLY = 2;
  localparam logic [1:0] ADC_REF_4096 = 2'h3;
  localparam logic [1:0] ADC_REF_2048 = 2'h2;
  localparam logic [1:0] ADC_REF_1024 = 2'h1;
  localparam logic [1:0] ADC_REF_OFF = 2'h0;

  // Idle level byte and divider byte fields
  localparam int BIT_RX_IDLE = 6;
  localparam int BIT_TX_IDLE = 5;
  localparam int BIT_SUSPEND_IDLE = 3;
  localparam int BIT_CONFIG_IDLE = 2;
  localparam int BIT_DIVIDER_HI = 4;
  localparam int DIVIDER_WIDTH = 5;

  // Pin settings byte fields
  localparam int BIT_PIN_LEVEL = 4;
  localparam int BIT_PIN_DIR = 3;
  localparam int BIT_PIN_CODE_HI = 2;
  localparam logic [2:0] CODE_GPIO = 3'h0;
  localparam logic [2:0] CODE_DEDICATED = 3'h1;
  localparam logic [2:0] CODE_ALT0 = 3'h2;
  localparam logic [2:0] CODE_ALT1 = 3'h3;
  localparam logic [2:0] CODE_ALT2 = 3'h4;

  // Requested current is reported in units of this many milliamperes
  localparam int MA_PER_UNIT = 2;

  typedef enum logic [0:0] {PHASE_IDLE, PHASE_SEND} reply_phase_type;

  typedef enum logic [3:0] {
    ROLE_GPIO, ROLE_SUSPEND, ROLE_RX, ROLE_CLOCK, ROLE_ANALOG,
    ROLE_TX, ROLE_INTERRUPT, ROLE_CONFIGURED, ROLE_DAC, ROLE_NONE
  } pin_role_type;

  // Designation code to pin function, per pin number
  function automatic pin_role_type decode_role(input logic [1:0] pin, input logic [2:0] code);
    pin_role_type role;
    role = ROLE_NONE;
    if (code == CODE_GPIO) begin
      role = ROLE_GPIO;
    end else if (pin == 2'h0) begin
      if (code == CODE_DEDICATED) role = ROLE_SUSPEND;
      else if (code == CODE_ALT0) role = ROLE_RX;
    end else if (pin == 2'h1) begin
      if (code == CODE_DEDICATED) role = ROLE_CLOCK;
      else if (code == CODE_ALT0) role = ROLE_ANALOG;
      else if (code == CODE_ALT1) role = ROLE_TX;
      else if (code == CODE_ALT2) role = ROLE_INTERRUPT;
    end else begin
      if (code == CODE_DEDICATED) role = ROLE_CONFIGURED;
      else if (code == CODE_ALT0) role = ROLE_ANALOG;
      else if (code == CODE_ALT1) role = ROLE_DAC;
    end
    return role;
  endfunction : decode_role

endpackage : settings_pkg

// ### core/clock_out_if.sv
// Carries the divider setting and the divided clock level between the pin logic and the divider.
// Assumes both ends sit on the same device clock.
`timescale 1ns/1ps
interface clock_out_if;
  logic enable;
  logic [4:0] divider;
  logic level;

  modport control (output enable, output divider, input level);
  modport divider_side (input enable, input divider, output level);
endinterface : clock_out_if

// ### core/clock_out_divider.sv
// Clock output divider for the pin designated as clock output.
// Assumes the device clock stands in for the internal USB clock; one half period is divider+1 cycles.
`timescale 1ns/1ps
module clock_out_divider (
  input wire logic clk_in,
  input wire logic rst_n_in,
  clock_out_if.divider_side link
);

  typedef struct packed {
    logic [4:0] count;
    logic level;
  } divider_state_type;

  divider_state_type s;
  divider_state_type next_s;

  // Count up to the divider, then toggle; held low while the pin has another use
  always_comb begin
    next_s = s;
    if (!rst_n_in || !link.enable) begin
      next_s = '0;
    end else if (s.count >= link.divider) begin
      next_s.count = 5'h00;
      next_s.level = ~s.level;
    end else begin
      next_s.count = s.count + 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    s <= next_s;
  end

  assign link.level = s.level;

  // Level only moves once the half period has run out
  a_clock_half_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    link.enable && $past(link.enable) && $changed(s.level) |-> $past(s.count) >= $past(link.divider))
    else $error("Clock output toggled before its half period ended");

  // A disabled output stays low
  a_clock_idle_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !link.enable |=> !s.level)
    else $error("Clock output moved while not designated");

endmodule : clock_out_divider

// ### bench/reply_sink.sv
// Consumer model for the settings reply stream, standing for the host side.
// Assumes the block holds index and byte until an edge with ready high.
`timescale 1ns/1ps
module reply_sink (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic [5:0] index_in,
  input wire logic [7:0] byte_in,
  input wire logic slow_in,
  output logic ready_out
);
  logic [7:0] got [0:63];
  logic [1:0] tick = 2'h0;
  // Slow mode takes one byte in four, so a stalled byte must stand
  always @(negedge clk_in) begin
    tick <= tick + 2'h1;
    ready_out <= !slow_in || tick == 2'h0;
  end
  logic was_valid = 1'b0;
  // A new reply wipes old bytes; each taken byte lands at the slot its index names, so skips show up
  always @(posedge clk_in) begin
    was_valid <= valid_in === 1'b1;
    if (valid_in === 1'b1 && !was_valid) begin
      for (int k = 0; k < 64; k++) got[k] <= 8'hxx;
    end
    if (valid_in === 1'b1 && ready_out) got[index_in] <= byte_in;
  end
endmodule : reply_sink

// ### bench/test_settings_readback_response.sv
// Self-checking bench for the settings readback block and its pin setup.
// Assumes settings are loaded while reset is low; pin wires are resolved here.
`timescale 1ns/1ps
module test_settings_readback_response;
  logic clk_in = 1'b0, rst_n_in = 1'b0, read_req_in = 1'b0, read_pins_in = 1'b0;
  logic usb_configured_in = 1'b0, suspend_in = 1'b0, rx_active_in = 1'b0;
  logic tx_active_in = 1'b0, int_clear_in = 1'b0, slow_sink = 1'b0;
  logic [7:0] idle_levels_in = 8'h00, clock_divider_in = 8'h00, chip_flags_in = 8'h00;
  logic [7:0] pin_zero_byte_in = 8'h00, pin_one_byte_in = 8'h00, pin_two_byte_in = 8'h00;
  logic [15:0] vendor_id_in = 16'h1a2b, product_id_in = 16'h3c4d;
  logic [7:0] power_attr_in = 8'ha0, current_in = 8'hff;
  logic [2:0] ext_pins = 3'h0, pin_out, pin_oe_out, gpio_level_out;
  logic reply_valid_out, reply_last_out, int_flag_out, adc_ref_off_out, dac_ref_supply_out, dac_out_en_out;
  logic [5:0] reply_index_out;
  logic [7:0] reply_byte_out, config_attr_out;
  logic [8:0] max_power_ma_out;
  logic [1:0] adc_ref_sel_out, analog_in_en_out;
  wire logic reply_ready_in;
  wire logic [2:0] pin_in;
  int num_errors = 0, comparisons = 0, cycles = 0;
  // A pin the block drives reads back its own level
  assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_pins);
  settings_readback_response i_dut (.clk_in, .rst_n_in, .idle_levels_in, .clock_divider_in,
    .chip_flags_in, .vendor_id_in, .product_id_in, .power_attr_in, .current_in, .pin_zero_byte_in,
    .pin_one_byte_in, .pin_two_byte_in, .read_req_in, .read_pins_in, .reply_ready_in, .reply_valid_out,
    .reply_index_out, .reply_byte_out, .reply_last_out, .config_attr_out, .max_power_ma_out,
    .adc_ref_sel_out, .adc_ref_off_out, .dac_ref_supply_out, .usb_configured_in, .suspend_in,
    .rx_active_in, .tx_active_in, .int_clear_in, .int_flag_out, .pin_in, .pin_out, .pin_oe_out,
    .gpio_level_out, .analog_in_en_out, .dac_out_en_out);
  reply_sink i_sink (.clk_in, .valid_in(reply_valid_out), .index_in(reply_index_out),
    .byte_in(reply_byte_out), .slow_in(slow_sink), .ready_out(reply_ready_in));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Settings are only taken while reset is low, so every setting change needs a reset
  task automatic setup(input logic [7:0] fl, z, o, t, idl, dv);
    @(negedge clk_in);
    rst_n_in = 1'b0;
    chip_flags_in = fl;
    pin_zero_byte_in = z;
    pin_one_byte_in = o;
    pin_two_byte_in = t;
    idle_levels_in = idl;
    clock_divider_in = dv;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask : setup
  // Request held into the reply with the other kind selected: it must be ignored
  task automatic reply(input logic pins, input logic slow, input logic [7:0] e [0:63]);
    int n;
    logic [7:0] m;
    slow_sink = slow;
    read_pins_in = pins;
    read_req_in = 1'b1;
    @(negedge clk_in);
    chk(reply_valid_out, 1'b1, "reply start");
    read_pins_in = !pins;
    repeat (4) @(negedge clk_in);
    read_req_in = 1'b0;
    n = 0;
    while (reply_valid_out === 1'b1 && n < 400) begin
      if (reply_index_out == 6'h3f) chk(reply_last_out, 1'b1, "last flag");
      @(negedge clk_in);
      n++;
    end
    repeat (2) @(negedge clk_in);
    chk(reply_valid_out, 1'b0, "reply end");
    for (n = 0; n < 64; n++) begin
      m = (n == 7 && !pins) ? 8'h7c : (pins && n > 3 && n < 7) ? 8'h1f : 8'hff;
      chk(i_sink.got[n] & m, e[n] & m, "reply byte");
    end
  endtask : reply
  task automatic t_chip();
    logic [7:0] e [0:63];
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      r = k[1:0];
      setup({3'h4, r, r[0], 2'h3}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk(adc_ref_sel_out, r, "adc ref");
      chk(adc_ref_off_out, r == 2'h0, "ref off");
      chk(dac_ref_supply_out, r[0], "dac ref");
    end
    chk(config_attr_out, 8'ha0, "attributes");
    chk(max_power_ma_out, 9'h1fe, "current");
    for (int k = 0; k < 64; k++) e[k] = 8'h00;
    e[0] = 8'hb0;
    e[2] = settings_pkg::CHIP_STRUCT_LEN;
    e[7] = 8'h9f;
    e[8] = 8'h2b;
    e[9] = 8'h1a;
    e[10] = 8'h4d;
    e[11] = 8'h3c;
    e[12] = 8'ha0;
    e[13] = 8'hff;
    reply(1'b0, 1'b0, e);
  endtask : t_chip
  task automatic t_pins();
    logic [7:0] e [0:63];
    ext_pins = 3'h0;
    setup(8'h00, 8'hf0, 8'he8, 8'h20, 8'h00, 8'h00);
    chk(pin_oe_out, 3'h5, "gpio drive");
    chk({pin_out[2], pin_out[0]}, 2'h1, "gpio level");
    ext_pins = 3'h2;
    repeat (3) @(negedge clk_in);
    chk(gpio_level_out[1], 1'b1, "gpio input");
    for (int k = 0; k < 64; k++) e[k] = 8'h00;
    e[0] = 8'hb0;
    e[2] = settings_pkg::PIN_STRUCT_LEN;
    e[4] = 8'hf0;
    e[5] = 8'he8;
    e[6] = 8'h20;
    reply(1'b1, 1'b1, e);
  endtask : t_pins
  // Direction bit set on dedicated pins must not stop them driving
  task automatic t_ind();
    setup(8'h00, 8'h09, 8'h0b, 8'h09, 8'h6c, 8'h00);
    for (int s = 0; s < 8; s++) begin
      {usb_configured_in, tx_active_in, suspend_in} = s[2:0];
      repeat (2) @(negedge clk_in);
      chk(pin_out, 3'h7 ^ s[2:0], "indicators");
      chk(pin_oe_out, 3'h7, "indicator drive");
    end
    setup(8'h00, 8'h02, 8'h02, 8'h03, 8'h00, 8'h00);
    rx_active_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(pin_out[0], 1'b1, "receive activity");
    chk({pin_oe_out[1], analog_in_en_out, dac_out_en_out}, 4'h3, "analog and dac");
    setup(8'h00, 8'h07, 8'h05, 8'h02, 8'h00, 8'h00);
    chk({pin_oe_out, analog_in_en_out}, 5'h02, "undefined codes");
    rx_active_in = 1'b0;
  endtask : t_ind
  task automatic edge_check(input logic v, input logic exp);
    ext_pins[1] = v;
    repeat (6) @(negedge clk_in);
    chk(int_flag_out, exp, "flag held");
    int_clear_in = 1'b1;
    @(negedge clk_in);
    int_clear_in = 1'b0;
    @(negedge clk_in);
    chk(int_flag_out, 1'b0, "flag cleared");
  endtask : edge_check
  // A pin held high through reset must not look like a rising edge; then each enable mix in turn
  task automatic t_int();
    ext_pins = 3'h2;
    setup(8'h20, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00);
    repeat (4) @(negedge clk_in);
    chk(int_flag_out, 1'b0, "no edge at release");
    for (int m = 1; m < 4; m++) begin
      ext_pins = 3'h0;
      setup({1'b0, m[1:0], 5'h00}, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00);
      edge_check(1'b1, m[0]);
      edge_check(1'b0, m[1]);
    end
  endtask : t_int
  task automatic half(output int n);
    logic v;
    v = pin_out[1];
    n = 0;
    while (pin_out[1] === v && n < 100) begin
      @(negedge clk_in);
      n++;
    end
  endtask : half
  task automatic t_clk();
    int n;
    logic [4:0] d [0:2] = '{5'h00, 5'h02, 5'h1f};
    for (int k = 0; k < 3; k++) begin
      setup(8'h00, 8'h00, 8'h01, 8'h00, 8'h00, {3'h7, d[k]});
      half(n);
      half(n);
      chk(n[15:0], {11'h000, d[k]} + 16'h0001, "half period");
      chk(pin_oe_out[1], 1'b1, "clock drive");
    end
  endtask : t_clk
  initial begin
    t_chip();
    $display("chip settings test done");
    t_pins();
    $display("pin settings test done");
    t_ind();
    $display("indicator test done");
    t_int();
    $display("interrupt test done");
    t_clk();
    $display("clock output test done");
    wrap_up();
  end
endmodule : test_settings_readback_response
